// ==== rtl/raa_top.sv ====
`timescale 1ns/100ps
`include "raa_regs.svh"

// How it works
// [R1] several attributes on one register: the most restrictive one wins
// [R2] denied access reads zero byte and drops the write
// [R3] unimplemented addresses behave like denied accesses
// [R4] ordinary registers open to serial port or eeprom, never both at once
// [R5] eeprom load or store active: eeprom owns registers, serial denied
// [R6] read-only registers stay readable always, even while eeprom is active
// [R7] eeprom-excluded registers are never stored nor loaded
// [R8] read-only registers are also excluded from eeprom transfers
// [R9] writes to unmapped addresses change no state
// [R10] live registers act at once; buffered copy moves on update, serial or divided clock
// [R11] host should write defaults into unused and reserved bits
// [R12] port config bits 7..4: unidirectional, address step direction, soft reset, long instr; reset 0x10
// [R13] readback select 0 returns active copy, 1 returns buffered copy
// [R14] update from update register bit 0 or from the update pin
// [R15] autoclear bits cleared by logic when their action completes
// [R16] decoder yields one attribute vector per address for both sources
module raa_top
  import raa_pkg::*;
#(
  parameter logic [7:0] SI_REV_VAL  = 8'h01,  // arbitrary value
  parameter logic [7:0] PART_ID_VAL = 8'h5a   // arbitrary value
)(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        sp_req_i,
  input  wire logic        sp_wr_i,
  input  wire logic [15:0] sp_addr_i,
  input  wire logic [7:0]  sp_wdata_i,
  output logic [7:0]       sp_rdata_o,
  output logic             sp_ack_o,
  input  wire logic        ee_busy_i,
  input  wire logic        ee_req_i,
  input  wire logic        ee_wr_i,
  input  wire logic [15:0] ee_addr_i,
  input  wire logic [7:0]  ee_wdata_i,
  output logic [7:0]       ee_rdata_o,
  output logic             ee_ack_o,
  input  wire logic        update_pin_i,
  output logic             unidir_o,
  output logic             address_step_direction_o,
  output logic             soft_reset_o,
  output logic             long_instr_o,
  output logic [7:0]       cp_ctrl_o,
  output logic [4:0]       per_hi_o,
  output logic             core_timebase_tick_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic raa_attr_t attr_of(input logic [15:0] a);
    raa_attr_t t;
    t = '0;
    if (a == `RAA_ADDR_PORT_CFG || a == `RAA_ADDR_RSVD_ONE || a == `RAA_ADDR_RB_SEL)
    begin
      t.impl = 1'b1; t.live = 1'b1; t.ee_x = 1'b1;
    end
    else if (a == `RAA_ADDR_SI_REV || a == `RAA_ADDR_PART_ID)
    begin
      t.impl = 1'b1; t.live = 1'b1; t.ro = 1'b1;
    end
    else if (a == `RAA_ADDR_UPDATE)
    begin
      t.impl = 1'b1; t.live = 1'b1; t.ee_x = 1'b1; t.autoclr = 1'b1;
    end
    else if (a == `RAA_ADDR_CP_CTRL)
    begin
      t.impl = 1'b1; t.buf_s = 1'b1;
    end
    else if (a == `RAA_ADDR_PER_HI)
    begin
      t.impl = 1'b1; t.buf_c = 1'b1;
    end
    return t;  // see [R16]
  endfunction

  raa_state_t q;
  raa_state_t d;
  raa_attr_t  sp_attr;
  raa_attr_t  ee_attr;
  logic       sp_rgrant;
  logic       sp_wgrant;
  logic       ee_rgrant;
  logic       ee_wgrant;
  logic       wr_go;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic       update_ev;
  logic       tick;

  function automatic logic [7:0] read_of(input raa_state_t s, input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == `RAA_ADDR_PORT_CFG)
      v = s.port_cfg_q & `RAA_PORT_CFG_MASK;
    else if (a == `RAA_ADDR_SI_REV)
      v = SI_REV_VAL;
    else if (a == `RAA_ADDR_PART_ID)
      v = PART_ID_VAL;
    else if (a == `RAA_ADDR_RB_SEL)
      v = {7'h00, s.rb_sel_q};
    else if (a == `RAA_ADDR_UPDATE)
      v = {7'h00, s.update_q};
    else if (a == `RAA_ADDR_CP_CTRL)
      v = s.rb_sel_q ? s.cp_buf_q : s.cp_act_q;  // see [R13]
    else if (a == `RAA_ADDR_PER_HI)
      v = {3'h0, s.rb_sel_q ? s.per_buf_q : s.per_act_q};  // see [R13]
    return v;
  endfunction

  // ---------------------------------------------------------------
  // grant logic
  // ---------------------------------------------------------------
  always_comb
  begin
    sp_attr = attr_of(sp_addr_i);
    ee_attr = attr_of(ee_addr_i);
    // eeprom owns everything but read-only while busy; idle eeprom gets nothing
    sp_rgrant = sp_req_i && !sp_wr_i && sp_attr.impl && (!ee_busy_i || sp_attr.ro);  // see [R5] see [R6]
    sp_wgrant = sp_req_i && sp_wr_i && sp_attr.impl && !sp_attr.ro && !ee_busy_i;  // see [R1] see [R4]
    ee_rgrant = ee_busy_i && ee_req_i && !ee_wr_i && ee_attr.impl && !ee_attr.ee_x && !ee_attr.ro;  // see [R7] see [R8]
    ee_wgrant = ee_busy_i && ee_req_i && ee_wr_i && ee_attr.impl && !ee_attr.ee_x && !ee_attr.ro;  // see [R7] see [R8]
    wr_go   = sp_wgrant || ee_wgrant;  // see [R4]
    wr_addr = ee_wgrant ? ee_addr_i : sp_addr_i;
    wr_data = ee_wgrant ? ee_wdata_i : sp_wdata_i;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    d = q;
    tick = (q.div_q == 5'(`RAA_CORE_DIV - 6'd1));
    d.div_q = q.div_q + 5'd1;
    d.pin_q = update_pin_i;
    // denied and unmapped writes fall through every branch below
    if (wr_go)  // see [R2] see [R3] see [R9]
    begin
      if (wr_addr == `RAA_ADDR_PORT_CFG)
        d.port_cfg_q = wr_data & `RAA_PORT_CFG_MASK;  // see [R12]
      else if (wr_addr == `RAA_ADDR_RB_SEL)
        d.rb_sel_q = wr_data[`RAA_BIT_RB_SEL];
      else if (wr_addr == `RAA_ADDR_UPDATE && wr_data[`RAA_BIT_UPDATE])
        d.update_q = 1'b1;
      else if (wr_addr == `RAA_ADDR_CP_CTRL)
        d.cp_buf_q = wr_data;
      else if (wr_addr == `RAA_ADDR_PER_HI)
        d.per_buf_q = wr_data[`RAA_PER_HI_W-1:0];
    end
    // limitation: an update raised while a divided-clock copy pends rides on that copy
    update_ev = (q.update_q && !q.c_pend_q) || (update_pin_i && !q.pin_q);  // see [R14]
    if (update_ev)
    begin
      d.cp_act_q = q.cp_buf_q;  // see [R10]
      d.c_pend_q = 1'b1;
    end
    // divided-clock copy waits for the next timebase tick
    if (q.c_pend_q && tick)
    begin
      d.per_act_q = q.per_buf_q;  // see [R10]
      d.c_pend_q  = update_ev;
    end
    // autoclear as the divided-clock copy moves; a fresh write keeps it set
    if (q.update_q && q.c_pend_q && tick && !(wr_go && wr_addr == `RAA_ADDR_UPDATE && wr_data[`RAA_BIT_UPDATE]))
      d.update_q = 1'b0;  // see [R15]
    d.sp_ack_q   = sp_req_i;
    d.sp_rdata_q = sp_rgrant ? read_of(q, sp_addr_i) : 8'h00;  // see [R2] see [R3]
    d.ee_ack_q   = ee_req_i;
    d.ee_rdata_q = ee_rgrant ? read_of(q, ee_addr_i) : 8'h00;  // see [R2]
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.port_cfg_q <= `RAA_RST_PORT_CFG;  // see [R12]
      q.rb_sel_q   <= `RAA_RST_RB_SEL;
      q.cp_buf_q   <= `RAA_RST_CP_CTRL;
      q.cp_act_q   <= `RAA_RST_CP_CTRL;
      q.per_buf_q  <= `RAA_RST_PER_HI;
      q.per_act_q  <= `RAA_RST_PER_HI;
    end
    else
      q <= d;
  end

  assign sp_rdata_o               = q.sp_rdata_q;
  assign sp_ack_o                 = q.sp_ack_q;
  assign ee_rdata_o               = q.ee_rdata_q;
  assign ee_ack_o                 = q.ee_ack_q;
  assign unidir_o                 = q.port_cfg_q[`RAA_BIT_UNIDIR];
  assign address_step_direction_o = q.port_cfg_q[`RAA_BIT_STEP_DIR];
  assign soft_reset_o             = q.port_cfg_q[`RAA_BIT_SOFT_RST];
  assign long_instr_o             = q.port_cfg_q[`RAA_BIT_LONG_INSTR];
  assign cp_ctrl_o                = q.cp_act_q;
  assign per_hi_o                 = q.per_act_q;
  assign core_timebase_tick_o     = tick;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_DENY_READ_ZERO: assert property ((sp_req_i && !sp_wr_i && !sp_rgrant) |=> sp_rdata_o == 8'h00)  // see [R2]
    else $error("denied read not zero");
  AST_UNMAPPED_WRITE: assert property ((sp_req_i && sp_wr_i && !sp_attr.impl && !ee_wgrant)
    |=> $stable({q.port_cfg_q, q.rb_sel_q, q.cp_buf_q, q.per_buf_q}))  // see [R3] see [R9]
    else $error("unmapped write changed state");
  AST_EE_OWNS: assert property ((ee_busy_i && sp_req_i && !sp_attr.ro) |-> !sp_rgrant && !sp_wgrant)  // see [R5]
    else $error("serial granted during eeprom activity");
  AST_ONE_SOURCE: assert property (!(sp_wgrant && (ee_wgrant || ee_rgrant)))  // see [R4]
    else $error("both sources granted");
  AST_RO_READABLE: assert property ((sp_req_i && !sp_wr_i && sp_addr_i == `RAA_ADDR_PART_ID)
    |=> sp_rdata_o == PART_ID_VAL)  // see [R6]
    else $error("read-only register not readable");
  AST_EE_EXCLUDED: assert property ((ee_req_i && (ee_attr.ee_x || ee_attr.ro))
    |-> !ee_rgrant && !ee_wgrant)  // see [R7] see [R8]
    else $error("eeprom reached excluded register");
  AST_BUF_S_MOVE: assert property (update_ev |=> cp_ctrl_o == $past(q.cp_buf_q))  // see [R10]
    else $error("serial buffered copy not moved");
  AST_BUF_C_MOVE: assert property ($rose(q.c_pend_q) |-> ##[1:33] !q.c_pend_q || $past(update_ev))  // see [R10]
    else $error("divided clock copy stuck");
  AST_RB_SELECT: assert property ((sp_rgrant && sp_addr_i == `RAA_ADDR_CP_CTRL)
    |=> sp_rdata_o == ($past(q.rb_sel_q) ? $past(q.cp_buf_q) : $past(q.cp_act_q)))  // see [R13]
    else $error("readback select wrong copy");
  AST_AUTOCLEAR: assert property ((q.update_q && !wr_go) |-> ##[1:34] !q.update_q)  // see [R15]
    else $error("update bit never cleared");
  AST_UPD_HOLD: assert property ((q.update_q && !q.c_pend_q) |=> q.update_q)  // see [R15]
    else $error("update bit cleared before copy moved");

  COV_UPDATE_REG: cover property (wr_go && wr_addr == `RAA_ADDR_UPDATE ##[1:40] !q.update_q);
  COV_EE_STORE:   cover property (ee_rgrant);
  COV_SP_DENIED:  cover property (ee_busy_i && sp_req_i && sp_wr_i);
  COV_PIN_UPDATE: cover property (update_pin_i && !q.pin_q);

endmodule

// ==== include/raa_regs.svh ====
`ifndef RAA_REGS_SVH
`define RAA_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RAA_ADDR_PORT_CFG   16'h0000
`define RAA_ADDR_RSVD_ONE   16'h0001
`define RAA_ADDR_SI_REV     16'h0002
`define RAA_ADDR_PART_ID    16'h0003
`define RAA_ADDR_RB_SEL     16'h0004
`define RAA_ADDR_UPDATE     16'h0005
`define RAA_ADDR_CP_CTRL    16'h0100
`define RAA_ADDR_PER_HI     16'h0105

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define RAA_RST_PORT_CFG    8'h10
`define RAA_RST_RB_SEL      1'b0
`define RAA_RST_CP_CTRL     8'h18
`define RAA_RST_PER_HI      5'h0f
`define RAA_BIT_UNIDIR      7
`define RAA_BIT_STEP_DIR    6
`define RAA_BIT_SOFT_RST    5
`define RAA_BIT_LONG_INSTR  4
`define RAA_PORT_CFG_MASK   8'hf0
`define RAA_BIT_RB_SEL      0
`define RAA_BIT_UPDATE      0
`define RAA_PER_HI_W        5

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RAA_CORE_DIV        6'd32
`define RAA_DIV_W           5

`endif

// ==== include/raa_pkg.sv ====
package raa_pkg;

  // per-address access attributes
  typedef struct packed {
    logic impl;
    logic ro;
    logic ee_x;
    logic live;
    logic buf_s;
    logic buf_c;
    logic autoclr;
  } raa_attr_t;

  typedef struct packed {
    logic [7:0] port_cfg_q;
    logic       rb_sel_q;
    logic       update_q;
    logic [7:0] cp_buf_q;
    logic [7:0] cp_act_q;
    logic [4:0] per_buf_q;
    logic [4:0] per_act_q;
    logic       c_pend_q;
    logic [4:0] div_q;
    logic       pin_q;
    logic [7:0] sp_rdata_q;
    logic       sp_ack_q;
    logic [7:0] ee_rdata_q;
    logic       ee_ack_q;
  } raa_state_t;

endpackage

// ==== tb/raa_ee_model.sv ====
`timescale 1ns/100ps
// eeprom controller side: holds busy across a session, one byte per request
module raa_ee_model (
  input  wire logic        ref_clk_i,
  input  wire logic [7:0]  ee_rdata_i,
  input  wire logic        ee_ack_i,
  output logic             ee_busy_o,
  output logic             ee_req_o,
  output logic             ee_wr_o,
  output logic [15:0]      ee_addr_o,
  output logic [7:0]       ee_wdata_o
);
  initial
  begin
    ee_busy_o  = 1'b0;
    ee_req_o   = 1'b0;
    ee_wr_o    = 1'b0;
    ee_addr_o  = 16'hffff;
    ee_wdata_o = 8'hff;
  end

  task automatic set_busy(input logic b);
    @(posedge ref_clk_i);
    ee_busy_o <= b;
  endtask

  // idle lines show the inverse so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic ack);
    @(posedge ref_clk_i);
    ee_req_o   <= 1'b1;
    ee_wr_o    <= wr;
    ee_addr_o  <= a;
    ee_wdata_o <= d;
    @(posedge ref_clk_i);
    ee_req_o   <= 1'b0;
    ee_addr_o  <= ~a;
    ee_wdata_o <= ~d;
    #1;
    rd  = ee_rdata_i;
    ack = ee_ack_i;
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import raa_pkg::*;
  logic        ref_clk_i, rst_b_i, sp_req, sp_wr, upd_pin, ee_busy, ee_req, ee_wr;
  logic        sp_ack, ee_ack, uni, step, srst, lng, tick;
  logic [15:0] sp_addr, ee_addr;
  logic [7:0]  sp_wdata, ee_wdata, sp_rdata, ee_rdata, cp;
  logic [4:0]  per;
  int          error_cnt, checked, cyc, n;

  raa_top raa_top_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sp_req_i(sp_req), .sp_wr_i(sp_wr),
    .sp_addr_i(sp_addr), .sp_wdata_i(sp_wdata), .sp_rdata_o(sp_rdata), .sp_ack_o(sp_ack),
    .ee_busy_i(ee_busy), .ee_req_i(ee_req), .ee_wr_i(ee_wr), .ee_addr_i(ee_addr),
    .ee_wdata_i(ee_wdata), .ee_rdata_o(ee_rdata), .ee_ack_o(ee_ack), .update_pin_i(upd_pin),
    .unidir_o(uni), .address_step_direction_o(step), .soft_reset_o(srst), .long_instr_o(lng),
    .cp_ctrl_o(cp), .per_hi_o(per), .core_timebase_tick_o(tick));
  raa_ee_model raa_ee_model_inst (.ref_clk_i(ref_clk_i), .ee_rdata_i(ee_rdata), .ee_ack_i(ee_ack),
    .ee_busy_o(ee_busy), .ee_req_o(ee_req), .ee_wr_o(ee_wr), .ee_addr_o(ee_addr), .ee_wdata_o(ee_wdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one access from either source, ack and data checked 1 ns after the taking edge
  task automatic acc(input logic ee, input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] exp);
    logic [7:0] rd;
    logic       ak;
    if (ee)
      raa_ee_model_inst.xfer(wr, a, d, rd, ak);
    else
    begin
      @(posedge ref_clk_i);
      sp_req   <= 1'b1;
      sp_wr    <= wr;
      sp_addr  <= a;
      sp_wdata <= d;
      @(posedge ref_clk_i);
      sp_req   <= 1'b0;
      sp_addr  <= ~a;
      sp_wdata <= ~d;
      #1;
      rd = sp_rdata;
      ak = sp_ack;
    end
    chk({7'h00, ak}, 8'h01);
    chk(rd, exp);
  endtask

  // ---------------------------------------------------------------
  // clock, reset, timeout
  // ---------------------------------------------------------------
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    rst_b_i = 1'b0; sp_req = 1'b0; sp_wr = 1'b0; sp_addr = 16'h0000; sp_wdata = 8'h00; upd_pin = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    chk({uni, step, srst, lng, 4'h0}, 8'h10);
    chk(cp, 8'h18);
    chk({3'h0, per}, 8'h0f);
    acc(0, 0, 16'h0000, 8'h00, 8'h10);
    acc(0, 0, 16'h0004, 8'h00, 8'h00);
    acc(0, 0, 16'h0002, 8'h00, 8'h01);
    acc(0, 0, 16'h0003, 8'h00, 8'h5a);
    acc(0, 1, 16'h0000, 8'hf0, 8'h00);
    chk({uni, step, srst, lng, 4'h0}, 8'hf0);
    acc(0, 1, 16'h0000, 8'h1f, 8'h00);
    acc(0, 0, 16'h0000, 8'h00, 8'h10);
    acc(0, 1, 16'h0003, 8'hff, 8'h00);
    acc(0, 0, 16'h0003, 8'h00, 8'h5a);
    acc(0, 0, 16'h0001, 8'h00, 8'h00);
    acc(0, 1, 16'h0200, 8'hff, 8'h00);
    acc(0, 0, 16'h0200, 8'h00, 8'h00);
    // buffered copies stay put until an update
    acc(0, 1, 16'h0100, 8'haa, 8'h00);
    acc(0, 1, 16'h0105, 8'he3, 8'h00);
    chk(cp, 8'h18);
    acc(0, 0, 16'h0100, 8'h00, 8'h18);
    acc(0, 1, 16'h0004, 8'h01, 8'h00);
    acc(0, 0, 16'h0100, 8'h00, 8'haa);
    acc(0, 0, 16'h0105, 8'h00, 8'h03);
    acc(0, 1, 16'h0005, 8'h01, 8'h00);
    // update bit must still stand while the divided-clock copy waits
    acc(0, 0, 16'h0005, 8'h00, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    chk(cp, 8'haa);
    repeat (40) @(posedge ref_clk_i);
    chk({3'h0, per}, 8'h03);
    acc(0, 0, 16'h0005, 8'h00, 8'h00);
    acc(0, 1, 16'h0100, 8'h55, 8'h00);
    @(posedge ref_clk_i) upd_pin <= 1'b1;
    @(posedge ref_clk_i) upd_pin <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk(cp, 8'h55);
    // divided timebase period, sampled mid-cycle to stay clear of the launching edge
    n = 0;
    while (tick !== 1'b1 && n < 40) @(negedge ref_clk_i) n++;
    n = 0;
    do @(negedge ref_clk_i) n++; while (tick !== 1'b1 && n < 40);
    chk(n[7:0], 8'h20);
    // eeprom controller ownership
    acc(1, 0, 16'h0100, 8'h00, 8'h00);
    raa_ee_model_inst.set_busy(1'b1);
    acc(0, 1, 16'h0100, 8'h77, 8'h00);
    acc(0, 0, 16'h0100, 8'h00, 8'h00);
    acc(0, 0, 16'h0003, 8'h00, 8'h5a);
    acc(1, 1, 16'h0100, 8'h33, 8'h00);
    acc(1, 0, 16'h0100, 8'h00, 8'h33);
    acc(1, 1, 16'h0000, 8'h00, 8'h00);
    acc(1, 0, 16'h0002, 8'h00, 8'h00);
    acc(1, 0, 16'h0004, 8'h00, 8'h00);
    raa_ee_model_inst.set_busy(1'b0);
    acc(0, 0, 16'h0100, 8'h00, 8'h33);
    acc(0, 0, 16'h0000, 8'h00, 8'h10);
    close_out();
  end
endmodule
